// ===== src/modem_ctrl_defines.svh
// Offsets, field positions and reset values of the modem control and status block.
`ifndef MODEM_CTRL_DEFINES_SVH
`define MODEM_CTRL_DEFINES_SVH

// ============================================================
// Register offsets on the three-bit register select.
`define OFF_DATA        3'h0
`define OFF_IRQ_MASK    3'h1
`define OFF_IRQ_STATUS  3'h2
`define OFF_LINE_CTRL   3'h3
`define OFF_MODEM_CTRL  3'h4
`define OFF_LINE_STATUS 3'h5
`define OFF_MODEM_STAT  3'h6
`define OFF_SCRATCH     3'h7

// ============================================================
// Modem control register fields.
`define MCR_TERM_READY  0
`define MCR_SEND_REQ    1
`define MCR_AUX         2
`define MCR_IRQ_ENABLE  3
`define MCR_LOOP        4

// ============================================================
// Modem status register fields.
`define MSR_CTS_CHG     0
`define MSR_DSR_CHG     1
`define MSR_RING_RISE   2
`define MSR_CARRIER_CHG 3
`define MSR_LEVEL_LSB   4

// ============================================================
// Modem input index, shared by the synchroniser and the change flags.
`define MIN_CTS         0
`define MIN_DSR         1
`define MIN_RING        2
`define MIN_CARRIER     3

// ============================================================
// Interrupt status and mask fields.
`define IRQ_RX_ERROR    0
`define IRQ_RX_AVAIL    1
`define IRQ_THR_EMPTY   2
`define IRQ_MODEM       3

// ============================================================
// Reset values.
`define RST_MCR         5'h00
`define RST_MASK        4'h0
`define RST_BYTE        8'h00
`define RST_MODEM_LEVEL 4'hf
`define RST_PIN_HIGH    1'b1
`define RST_PIN_LOW     1'b0

`endif

// ===== src/modem_ctrl_pkg.sv
// Types shared by the modem control and status block and its bench.
package modem_ctrl_pkg;

    // ============================================================
    // Register bus request, driven by the processor side.
    typedef struct packed {
        logic       cs_n;
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    // ============================================================
    // Register bus answer; oe is high while the block drives the data bus.
    typedef struct packed {
        logic [7:0] rdata;
        logic       oe;
    } bus_rsp_t;

    // ============================================================
    // Modem handshake inputs, all active low.
    typedef struct packed {
        logic carrier_detect_in;
        logic ring_n;
        logic dsr_n;
        logic cts_n;
    } modem_in_t;

    // ============================================================
    // Modem handshake outputs, all active low except the serial line.
    typedef struct packed {
        logic serial_out;
        logic rts_n;
        logic dtr_n;
    } modem_out_t;

    // ============================================================
    // Whole state of the block.
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] level_n;
        logic [3:0] change;
        logic [4:0] modem_control_reg;
        logic [3:0] mask;
        logic [3:0] irq_status;
        logic [7:0] line_ctrl;
        logic [7:0] scratch;
        logic [7:0] rdata;
        logic       rdata_oe;
        logic       serial_out;
        logic       dtr_n;
        logic       rts_n;
        logic       irq;
        logic       irq_oe;
    } state_t;

endpackage : modem_ctrl_pkg

// ===== src/serial_modem_control_status.sv
// Modem handshake control, modem status tracking and interrupt logic of one serial channel.
//
// Notes on behaviour
// - Terminal-ready low when control bit 0 set.
// - Terminal-ready inactive on reset and loop mode.
// - Send-request low when control bit 1 set.
// - Send-request inactive on reset and loop mode.
// - Interrupt driver enabled only by control bit 3.
// - Interrupt from four causes.
// - Interrupt low after service and on reset.
// - Status bit 6 shows ring level.
// - Status bit 2 set when ring ends (ring_n rising).
// - Status bit 7 shows carrier detect level.
// - Status bit 3 set on carrier change.
// - Enabled modem change raises the interrupt.
// - Data bus driven only in the cycle after a selected read.
// - Selected write loads the addressed register, except data, line status and modem status, which ignore writes; interrupt status clears written ones.
// - Reset clears registers, sets output reset levels.
// - Clear-to-send level bit 4, change bit 0.
// - Data-set-ready level bit 5, change bit 1.
// - Serial output marks high during reset.
`timescale 1ns/1ps
`include "modem_ctrl_defines.svh"

module serial_modem_control_status
    import modem_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire bus_req_t   bus_req,
    output bus_rsp_t        bus_rsp,
    input  wire modem_in_t  modem_in,
    output modem_out_t      modem_out,
    input  wire logic       tx_bit,
    input  wire logic       rx_error_evt,
    input  wire logic       rx_avail_evt,
    input  wire logic       thr_empty_evt,
    output logic            channel_irq_out,
    output logic            channel_irq_oe
);

    // ============================================================
    // Decoding helpers.

    // A strobe counts only while the channel is selected.
    function automatic logic strobe_hit(input logic cs_n, input logic strobe_n);
        strobe_hit = !cs_n && !strobe_n;
    endfunction : strobe_hit

    // Register select match, used by the modem status read that clears the change flags.
    function automatic logic at_offset(input logic [2:0] addr, input logic [2:0] off);
        at_offset = (addr == off);
    endfunction : at_offset

    // ============================================================
    // State.
    state_t     state_ff;
    state_t     nxt_state;

    // ============================================================
    // Next-state logic.  Every register is updated from this one process.
    always_comb begin
        logic       rd;
        logic       wr;
        logic       loop;
        logic [3:0] raw_n;
        logic [3:0] settled_n;
        logic [3:0] toggled;
        logic [3:0] events;
        logic [3:0] irq_events;
        logic [7:0] msr_view;

        rd         = 1'b0;
        wr         = 1'b0;
        loop       = 1'b0;
        raw_n      = 4'h0;
        settled_n  = 4'h0;
        toggled    = 4'h0;
        events     = 4'h0;
        irq_events = 4'h0;
        msr_view   = 8'h00;
        nxt_state  = state_ff;

        rd   = strobe_hit(bus_req.cs_n, bus_req.read_strobe_n);
        wr   = strobe_hit(bus_req.cs_n, bus_req.write_strobe_n);
        loop = state_ff.modem_control_reg[`MCR_LOOP];

        // In loop mode the modem inputs are taken from the control bits, so
        // software can exercise the status path without a modem attached.
        raw_n[`MIN_CTS]     = ~state_ff.modem_control_reg[`MCR_SEND_REQ];
        raw_n[`MIN_DSR]     = ~state_ff.modem_control_reg[`MCR_TERM_READY];
        raw_n[`MIN_RING]    = ~state_ff.modem_control_reg[`MCR_AUX];
        raw_n[`MIN_CARRIER] = ~state_ff.modem_control_reg[`MCR_IRQ_ENABLE];
        if (!loop) begin
            raw_n = modem_in;
        end

        // Three-stage synchroniser; the first stage feeds only the second.
        nxt_state.sync1 = raw_n;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.sync3 = state_ff.sync2;

        // A new level is accepted only when the second and third stages agree,
        // which filters a single-cycle glitch at the cost of one cycle latency.
        settled_n = state_ff.level_n;
        for (int i = 0; i < 4; i++) begin
            if (state_ff.sync2[i] == state_ff.sync3[i]) begin
                settled_n[i] = state_ff.sync3[i];
            end
        end
        nxt_state.level_n = settled_n;
        toggled           = settled_n ^ state_ff.level_n;

        // Change events.
        events[`MSR_CTS_CHG]     = toggled[`MIN_CTS];
        events[`MSR_DSR_CHG]     = toggled[`MIN_DSR];
        events[`MSR_RING_RISE]   = toggled[`MIN_RING] && settled_n[`MIN_RING];
        events[`MSR_CARRIER_CHG] = toggled[`MIN_CARRIER];

        // Modem status as software sees it: levels inverted to active high.
        msr_view[`MSR_LEVEL_LSB + `MIN_CTS]     = ~state_ff.level_n[`MIN_CTS];
        msr_view[`MSR_LEVEL_LSB + `MIN_DSR]     = ~state_ff.level_n[`MIN_DSR];
        msr_view[`MSR_LEVEL_LSB + `MIN_RING]    = ~state_ff.level_n[`MIN_RING];
        msr_view[`MSR_LEVEL_LSB + `MIN_CARRIER] = ~state_ff.level_n[`MIN_CARRIER];
        msr_view[`MSR_CARRIER_CHG:`MSR_CTS_CHG] = state_ff.change;

        // Reading the modem status clears the change flags; a change arriving
        // in the same cycle survives so it is reported on the next read.
        if (rd && at_offset(bus_req.addr, `OFF_MODEM_STAT)) begin
            nxt_state.change = 4'h0;
        end
        nxt_state.change = nxt_state.change | events;

        // Register writes.
        if (wr) begin
            unique case (bus_req.addr)
                `OFF_IRQ_MASK:   nxt_state.mask = bus_req.wdata[3:0];
                `OFF_IRQ_STATUS: nxt_state.irq_status = state_ff.irq_status & ~bus_req.wdata[3:0];
                `OFF_LINE_CTRL:  nxt_state.line_ctrl = bus_req.wdata;
                `OFF_MODEM_CTRL: nxt_state.modem_control_reg = bus_req.wdata[4:0];
                `OFF_SCRATCH:    nxt_state.scratch = bus_req.wdata;
                default: begin
                end
            endcase
        end

        // Interrupt causes are sticky; set wins over a write-one clear.
        irq_events[`IRQ_RX_ERROR]  = rx_error_evt;
        irq_events[`IRQ_RX_AVAIL]  = rx_avail_evt;
        irq_events[`IRQ_THR_EMPTY] = thr_empty_evt;
        irq_events[`IRQ_MODEM]     = |events;
        nxt_state.irq_status = nxt_state.irq_status | irq_events;

        // Level interrupt: high while an unmasked cause is pending.
        nxt_state.irq    = |(nxt_state.irq_status & nxt_state.mask);
        nxt_state.irq_oe = nxt_state.modem_control_reg[`MCR_IRQ_ENABLE];

        // Handshake outputs are active low and forced off in loop mode.
        nxt_state.dtr_n = ~(nxt_state.modem_control_reg[`MCR_TERM_READY] && !nxt_state.modem_control_reg[`MCR_LOOP]);
        nxt_state.rts_n = ~(nxt_state.modem_control_reg[`MCR_SEND_REQ] && !nxt_state.modem_control_reg[`MCR_LOOP]);

        // The line marks in loop mode so the far end sees an idle line.
        nxt_state.serial_out = nxt_state.modem_control_reg[`MCR_LOOP] ? `RST_PIN_HIGH : tx_bit;

        // Read path: data stand one cycle after the strobe and only then.
        nxt_state.rdata_oe = rd;
        nxt_state.rdata    = `RST_BYTE;
        if (rd) begin
            unique case (bus_req.addr)
                `OFF_IRQ_MASK:   nxt_state.rdata = {4'h0, state_ff.mask};
                `OFF_IRQ_STATUS: nxt_state.rdata = {4'h0, state_ff.irq_status};
                `OFF_LINE_CTRL:  nxt_state.rdata = state_ff.line_ctrl;
                `OFF_MODEM_CTRL: nxt_state.rdata = {3'h0, state_ff.modem_control_reg};
                `OFF_MODEM_STAT: nxt_state.rdata = msr_view;
                `OFF_SCRATCH:    nxt_state.rdata = state_ff.scratch;
                default:         nxt_state.rdata = `RST_BYTE;
            endcase
        end

        // Synchronous reset: clear registers, park outputs at their idle levels.
        if (!rst_n) begin
            nxt_state.sync1      = `RST_MODEM_LEVEL;
            nxt_state.sync2      = `RST_MODEM_LEVEL;
            nxt_state.sync3      = `RST_MODEM_LEVEL;
            nxt_state.level_n    = `RST_MODEM_LEVEL;
            nxt_state.change     = 4'h0;
            nxt_state.modem_control_reg        = `RST_MCR;
            nxt_state.mask       = `RST_MASK;
            nxt_state.irq_status = 4'h0;
            nxt_state.line_ctrl  = `RST_BYTE;
            nxt_state.scratch    = `RST_BYTE;
            nxt_state.rdata      = `RST_BYTE;
            nxt_state.rdata_oe   = `RST_PIN_LOW;
            nxt_state.serial_out = `RST_PIN_HIGH;
            nxt_state.dtr_n      = `RST_PIN_HIGH;
            nxt_state.rts_n      = `RST_PIN_HIGH;
            nxt_state.irq        = `RST_PIN_LOW;
            nxt_state.irq_oe     = `RST_PIN_LOW;
        end
    end

    // ============================================================
    // State register.
    always_ff @(posedge clk) begin
        state_ff <= nxt_state;
    end

    // ============================================================
    // Outputs, all straight from flip-flops.
    assign bus_rsp.rdata        = state_ff.rdata;
    assign bus_rsp.oe           = state_ff.rdata_oe;
    assign modem_out.dtr_n      = state_ff.dtr_n;
    assign modem_out.rts_n      = state_ff.rts_n;
    assign modem_out.serial_out = state_ff.serial_out;
    assign channel_irq_out      = state_ff.irq;
    assign channel_irq_oe       = state_ff.irq_oe;

endmodule : serial_modem_control_status

// ===== testbench/serial_modem_control_status_sva.sv
// Concurrent checks on the ports of the modem control and status block.
`timescale 1ns/1ps

module serial_modem_control_status_sva
    import modem_ctrl_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire bus_req_t   bus_req,
    input wire bus_rsp_t   bus_rsp,
    input wire modem_in_t  modem_in,
    input wire modem_out_t modem_out,
    input wire logic       tx_bit,
    input wire logic       rx_error_evt,
    input wire logic       rx_avail_evt,
    input wire logic       thr_empty_evt,
    input wire logic       channel_irq_out,
    input wire logic       channel_irq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // Helper logic.
    wire logic       sel_wr = !bus_req.cs_n && !bus_req.write_strobe_n;
    wire logic       sel_rd = !bus_req.cs_n && !bus_req.read_strobe_n;
    wire logic       any_ev = rx_error_evt || rx_avail_evt || thr_empty_evt;
    logic      [3:0] mask_ff;

    // Shadow of the interrupt mask, so event checks know which causes may fire.
    always_ff @(posedge clk) begin
        if (!rst_n)
            mask_ff <= 4'h0;
        else if (sel_wr && bus_req.addr == 3'h1)
            mask_ff <= bus_req.wdata[3:0];
    end

    sequence mcr_write;
        sel_wr && bus_req.addr == 3'h4;
    endsequence

    sequence masked_event;
        (rx_error_evt && mask_ff[0]) || (rx_avail_evt && mask_ff[1]) || (thr_empty_evt && mask_ff[2]);
    endsequence

    // ============================================================
    // Assertions.
    a_read_drives_bus: assert property (sel_rd |=> bus_rsp.oe)
        else $error("bus not driven after selected read");
    a_bus_drive_cause: assert property (bus_rsp.oe |-> $past(sel_rd))
        else $error("bus driven without selected read");
    a_idle_data_zero: assert property (!bus_rsp.oe |-> bus_rsp.rdata == 8'h00)
        else $error("read data nonzero while idle");
    a_term_ready_ctl: assert property (mcr_write |=>
        modem_out.dtr_n == !($past(bus_req.wdata[0]) && !$past(bus_req.wdata[4])))
        else $error("terminal ready level wrong");
    a_send_req_ctl: assert property (mcr_write |=>
        modem_out.rts_n == !($past(bus_req.wdata[1]) && !$past(bus_req.wdata[4])))
        else $error("send request level wrong");
    a_irq_drive_en: assert property (mcr_write |=> channel_irq_oe == $past(bus_req.wdata[3]))
        else $error("interrupt enable not from control bit 3");
    a_reset_levels: assert property ($rose(rst_n) |-> modem_out == 3'h7
        && !channel_irq_out && !channel_irq_oe && !bus_rsp.oe)
        else $error("outputs not at reset levels");
    a_event_raises_irq: assert property (masked_event |=> channel_irq_out)
        else $error("unmasked event gave no interrupt");
    a_service_drops_irq: assert property (sel_wr && bus_req.addr == 3'h2 && bus_req.wdata[3:0] == 4'hf
        && !any_ev |=> !channel_irq_out)
        else $error("interrupt stayed high after service");
endmodule : serial_modem_control_status_sva

bind serial_modem_control_status serial_modem_control_status_sva u_sva (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .modem_in(modem_in), .modem_out(modem_out), .tx_bit(tx_bit),
    .rx_error_evt(rx_error_evt), .rx_avail_evt(rx_avail_evt), .thr_empty_evt(thr_empty_evt),
    .channel_irq_out(channel_irq_out), .channel_irq_oe(channel_irq_oe));

// ===== testbench/modem_partner.sv
// Behavioural modem that answers terminal ready and send request after a delay.
`timescale 1ns/1ps

module modem_partner
    import modem_ctrl_pkg::*;
#(
    parameter int DELAY = 1
)
(
    input  wire logic       clk,
    input  wire modem_out_t modem_out,
    input  wire logic       ring_n,
    input  wire logic       carrier_n,
    output modem_in_t       modem_in
);
    logic [7:0] dtr_q = 8'hff;
    logic [7:0] rts_q = 8'hff;

    // Delay lines model a slow modem; DELAY of 1 answers on the next edge.
    always_ff @(posedge clk) begin
        dtr_q <= {dtr_q[6:0], modem_out.dtr_n};
        rts_q <= {rts_q[6:0], modem_out.rts_n};
    end

    assign modem_in = '{carrier_detect_in: carrier_n, ring_n: ring_n,
                        dsr_n: dtr_q[DELAY-1], cts_n: rts_q[DELAY-1]};
endmodule : modem_partner

// ===== testbench/tb_top.sv
// Self-checking bench for the modem control and status block.
`timescale 1ns/1ps

module tb_top
    import modem_ctrl_pkg::*;
;
    typedef struct packed {logic cs; logic wr; logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    localparam bus_req_t IDLE = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
    localparam row_t ROWS [12] = '{'{1, 1, 1, 5, 0}, '{1, 0, 1, 0, 5}, '{1, 1, 3, 'ha5, 0},
        '{1, 0, 3, 0, 'ha5}, '{1, 1, 7, 'h5a, 0}, '{0, 1, 7, 'hff, 0}, '{1, 0, 7, 0, 'h5a},
        '{1, 0, 0, 0, 0}, '{1, 0, 5, 0, 0}, '{1, 1, 4, 'hff, 0}, '{1, 0, 4, 0, 'h1f}, '{1, 1, 4, 'h0b, 0}};
    logic       clk = 0, rst_n = 0, ring_n = 1, car_n = 1, irq, irq_oe;
    logic [2:0] ev = 3'h0;
    bus_req_t   req = IDLE;
    bus_rsp_t   rsp;
    modem_in_t  mi;
    modem_out_t mo;
    int         n_errors = 0, n_checks = 0;
    wire logic [7:0] pins = {3'h0, irq_oe, irq, mo};

    always #2.5 clk = ~clk;

    serial_modem_control_status u_dut (.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp),
        .modem_in(mi), .modem_out(mo), .tx_bit(1'b1), .rx_error_evt(ev[0]), .rx_avail_evt(ev[1]),
        .thr_empty_evt(ev[2]), .channel_irq_out(irq), .channel_irq_oe(irq_oe));
    modem_partner #(.DELAY(3)) u_modem (.clk(clk), .modem_out(mo), .ring_n(ring_n), .carrier_n(car_n),
        .modem_in(mi));

    // ============================================================
    // Tasks.
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // One bus cycle; returns just after the taking edge so its effects are settled.
    task automatic bus(input logic cs, input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{!cs, wr, !wr, a, d};
        @(posedge clk);
        req <= IDLE;
        #1;
    endtask : bus

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        bus(1, 0, a, 8'h00);
        chk(rsp.rdata, e);
        chk({7'h00, rsp.oe}, 8'h01);
    endtask : rd

    // Waits out the partner delay and the input synchroniser, then reads modem status.
    task automatic msr(input logic [7:0] e);
        repeat (12) @(posedge clk);
        rd(3'h6, e);
    endtask : msr

    task automatic pulse(input int i, input logic [7:0] e);
        @(posedge clk) ev <= 3'(1 << i);
        @(posedge clk) ev <= 3'h0;
        #1 chk(pins, e);
    endtask : pulse

    // A hang is cut short here and counted.
    initial begin
        #50us n_errors++;
        end_of_test();
    end

    // ============================================================
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        #1 chk(pins, 8'h07);
        @(posedge clk) rst_n <= 1;
        $display("reset test done");
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) bus(ROWS[i].cs, 1, ROWS[i].a, ROWS[i].d);
            else rd(ROWS[i].a, ROWS[i].e);
        end
        chk(pins, 8'h14);
        bus(1, 1, 3'h4, 8'h1b);
        chk(pins, 8'h17);
        bus(1, 1, 3'h4, 8'h00);
        msr(8'h0f);
        $display("register test done");
        bus(1, 1, 3'h4, 8'h03);
        msr(8'h33);
        msr(8'h30);
        ring_n <= 0;
        msr(8'h70);
        ring_n <= 1;
        msr(8'h34);
        bus(1, 1, 3'h2, 8'h0f);
        bus(1, 1, 3'h1, 8'h08);
        car_n <= 0;
        msr(8'hb8);
        chk(pins, 8'h0c);
        rd(3'h2, 8'h08);
        bus(1, 1, 3'h2, 8'h0f);
        chk(pins, 8'h04);
        car_n <= 1;
        msr(8'h38);
        chk(pins, 8'h0c);
        bus(1, 1, 3'h2, 8'h0f);
        $display("modem test done");
        for (int i = 0; i < 3; i++) begin
            bus(1, 1, 3'h1, 8'(1 << i));
            pulse(i, 8'h0c);
            bus(1, 1, 3'h2, 8'h0f);
            chk(pins, 8'h04);
        end
        bus(1, 1, 3'h1, 8'h00);
        pulse(0, 8'h04);
        rd(3'h2, 8'h01);
        $display("interrupt test done");
        @(posedge clk) rst_n <= 0;
        repeat (3) @(posedge clk);
        #1 chk(pins, 8'h07);
        $display("second reset test done");
        end_of_test();
    end
endmodule : tb_top
